/* ssc_pkg.sv */
// Shared constants, register map and pin carrier for the step sequencer control
`default_nettype none

package ssc_pkg;

	// Step count and row counts
	localparam int STEPS_DEF  = 8;
	localparam int STEPS_MAX  = 8;
	localparam int ROWS       = 2;
	localparam int TRIG_ROWS  = 3;
	localparam int ROW_LEDS   = 4;
	localparam int SEL_W      = 4;

	// Register bus geometry
	localparam int ADDR_W     = 4;
	localparam int DATA_W     = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CMD    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_SWITCH = 4'h8;

	// Command register bits, write-only pulses
	localparam int CMD_RUN    = 0;
	localparam int CMD_HALT   = 1;
	localparam int CMD_STEP   = 2;
	localparam int CMD_RETURN = 3;

	// Status register fields
	localparam int ST_RUNNING = 0;
	localparam int ST_POS_LSB = 4;
	localparam int ST_HOLD    = 8;
	localparam int ST_RETURN  = 9;
	localparam int ST_GLIDE   = 12;

	// Switch nibble layout: upper selector low, lower selector high
	localparam int SW_UP_LSB  = 0;
	localparam int SW_LO_LSB  = 2;
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_A    = 2'h1;
	localparam logic [1:0] SEL_B    = 2'h2;

	// Decoded row bit positions
	localparam int ROW_T1   = 0;
	localparam int ROW_T2   = 1;
	localparam int ROW_T3   = 2;
	localparam int ROW_GATE = 3;

	// Reset values
	localparam logic [DATA_W-1:0] SWITCH_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RDATA_RST  = 32'h0000_0000;

	// Control pins as seen at the socket side
	typedef struct packed {
		logic            run;
		logic            halt;
		logic            step;
		logic            ret;
		logic            hold;
		logic [ROWS-1:0] glide_n;
		logic [ROWS-1:0] glide_conn;
	} ssc_pins_s;

	// Run state of the sequence
	typedef enum logic {
		SSC_STOPPED,
		SSC_RUNNING
	} ssc_run_e;

endpackage : ssc_pkg

`default_nettype wire

/* ssc_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`default_nettype none

module ssc_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output var  logic [W-1:0] sync_o
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : ssc_sync

`default_nettype wire

/* ssc_top.sv */
// Run, step and row control of an eight-step sequencer
`default_nettype none

// What this block does
// - Run request sets sequence running
// - Halt request stops further step advances
// - One step advance per clock pulse
// - Return input puts position at step one
// - Run and halt act on rising edges
// - Pulse length never changes the command
// - Return high holds position at step one
// - Step clock advances on its rising edge
// - Glide enabled while control input low
// - Unconnected glide control means glide on
// - Hold high freezes the processed output
// - Trigger into halt gives one-shot run
// - Trigger into return shortens sequence
// - Eight steps, one lit indicator each
// - Trigger rows pulse, gate spans step
// - Two three-way selectors per step
module ssc_top #(
	parameter int NUM_STEPS = ssc_pkg::STEPS_DEF
) (
	input  wire logic                              mclk_i,
	input  wire logic                              rst_i,
	input  wire ssc_pkg::ssc_pins_s                pins_i,
	input  wire logic [ssc_pkg::ADDR_W-1:0]        reg_addr_i,
	input  wire logic [ssc_pkg::DATA_W-1:0]        reg_wdata_i,
	input  wire logic                              reg_we_i,
	input  wire logic                              reg_re_i,
	output var  logic [ssc_pkg::DATA_W-1:0]        reg_rdata_o,
	output var  logic [NUM_STEPS-1:0]              step_led_o,
	output var  logic [ssc_pkg::TRIG_ROWS-1:0]     trig_o,
	output var  logic                              gate_o,
	output var  logic [ssc_pkg::ROW_LEDS-1:0]      row_led_o,
	output var  logic [ssc_pkg::ROWS-1:0]          glide_en_o,
	output var  logic [$clog2(NUM_STEPS)-1:0]      hold_pos_o,
	output var  logic                              running_o
);

	localparam int POS_W = $clog2(NUM_STEPS);
	localparam int PIN_W = $bits(ssc_pkg::ssc_pins_s);
	localparam int SW_W  = NUM_STEPS * ssc_pkg::SEL_W;
	localparam logic [POS_W-1:0] POS_FIRST = '0;
	localparam logic [POS_W-1:0] POS_LAST  = POS_W'(NUM_STEPS - 1);
	localparam logic [POS_W-1:0] POS_ONE   = POS_W'(1);

	// The switch bank must fit one data word; refused while elaborating
	if (NUM_STEPS < 2 || NUM_STEPS > ssc_pkg::STEPS_MAX) begin : g_bad_steps
		$error("NUM_STEPS out of range");
	end

	// Decode one step's selector nibble into the four row bits
	function automatic logic [ssc_pkg::ROW_LEDS-1:0] row_decode(input logic [ssc_pkg::SEL_W-1:0] nib);
		logic [1:0]                    up;
		logic [1:0]                    lo;
		logic [ssc_pkg::ROW_LEDS-1:0]  r;
		up = nib[ssc_pkg::SW_UP_LSB +: 2];
		lo = nib[ssc_pkg::SW_LO_LSB +: 2];
		r  = '0;
		r[ssc_pkg::ROW_T1]   = (up == ssc_pkg::SEL_A);
		r[ssc_pkg::ROW_T2]   = (up == ssc_pkg::SEL_B);
		r[ssc_pkg::ROW_T3]   = (lo == ssc_pkg::SEL_A);
		r[ssc_pkg::ROW_GATE] = (lo == ssc_pkg::SEL_B);
		return r;
	endfunction : row_decode

	// Synchronised pin levels and their previous values
	logic [PIN_W-1:0]        pins_vec;
	ssc_pkg::ssc_pins_s      pins;
	ssc_pkg::ssc_pins_s      prev_q;

	// Sequencer state
	ssc_pkg::ssc_run_e       run_q;
	ssc_pkg::ssc_run_e       run_d;
	logic [POS_W-1:0]        pos_q;
	logic [POS_W-1:0]        pos_d;
	logic [SW_W-1:0]         switch_q;

	// Registered outputs and their next values
	logic [POS_W-1:0]              hold_pos_d;
	logic [ssc_pkg::TRIG_ROWS-1:0] trig_d;
	logic                          gate_d;
	logic [ssc_pkg::ROW_LEDS-1:0]  row_led_d;
	logic [NUM_STEPS-1:0]          step_led_d;
	logic [ssc_pkg::ROWS-1:0]      glide_en_d;
	logic [ssc_pkg::DATA_W-1:0]    rdata_d;

	// Every pin passes two flops before anything looks at it
	ssc_sync #(
		.W (PIN_W)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.async_i (pins_i),
		.sync_o  (pins_vec)
	);

	assign pins = ssc_pkg::ssc_pins_s'(pins_vec);

	// Register bus decode
	wire cmd_wr    = reg_we_i && (reg_addr_i == ssc_pkg::REG_CMD);
	wire switch_wr = reg_we_i && (reg_addr_i == ssc_pkg::REG_SWITCH);
	wire sw_run    = cmd_wr && reg_wdata_i[ssc_pkg::CMD_RUN];
	wire sw_halt   = cmd_wr && reg_wdata_i[ssc_pkg::CMD_HALT];
	wire sw_step   = cmd_wr && reg_wdata_i[ssc_pkg::CMD_STEP];
	wire sw_return = cmd_wr && reg_wdata_i[ssc_pkg::CMD_RETURN];

	// Rising edges only, so a long pulse still gives one command
	wire run_edge  = pins.run && !prev_q.run;
	wire halt_edge = pins.halt && !prev_q.halt;
	wire clk_rise  = pins.step && !prev_q.step;

	// Pins and software buttons merge into one command each
	wire run_cmd   = run_edge || sw_run;
	wire halt_cmd  = halt_edge || sw_halt;
	wire ret_level = pins.ret || sw_return;
	wire clk_level = pins.step || sw_step;

	// A pulse advances only a running, unreturned sequence
	wire running   = (run_q == ssc_pkg::SSC_RUNNING);
	wire advance   = running && (clk_rise || sw_step) && !ret_level;

	// Halt beats a coincident run: a trigger on the last step into halt must win
	always_comb begin
		run_d = run_q;
		if (halt_cmd) begin
			run_d = ssc_pkg::SSC_STOPPED;
		end else if (run_cmd) begin
			run_d = ssc_pkg::SSC_RUNNING;
		end
		case (run_q)
			ssc_pkg::SSC_STOPPED: ;
			ssc_pkg::SSC_RUNNING: ;
			default: run_d = ssc_pkg::SSC_STOPPED;
		endcase
	end

	// Step position: return level dominates, then advance with wrap
	always_comb begin
		pos_d = pos_q;
		if (ret_level) begin
			pos_d = POS_FIRST;
		end else if (advance) begin
			if (pos_q == POS_LAST) begin
				pos_d = POS_FIRST;
			end else begin
				pos_d = pos_q + POS_ONE;
			end
		end
	end

	// Rows for the step about to be shown
	wire [ssc_pkg::SEL_W-1:0]    cur_nib  = switch_q[pos_d * ssc_pkg::SEL_W +: ssc_pkg::SEL_W];
	wire [ssc_pkg::ROW_LEDS-1:0] cur_rows = row_decode(cur_nib);

	// Triggers follow the clock level, so their width matches the pulse
	wire trig_window = running && clk_level && !ret_level;

	assign trig_d     = cur_rows[ssc_pkg::TRIG_ROWS-1:0] & {ssc_pkg::TRIG_ROWS{trig_window}};
	assign gate_d     = cur_rows[ssc_pkg::ROW_GATE];
	assign row_led_d  = cur_rows;

	// One lit indicator per step
	genvar gs;
	generate
		for (gs = 0; gs < NUM_STEPS; gs++) begin : g_led
			assign step_led_d[gs] = (pos_d == POS_W'(gs));
		end
	endgenerate

	// Glide per row: low or unplugged enables it
	genvar gr;
	generate
		for (gr = 0; gr < ssc_pkg::ROWS; gr++) begin : g_glide
			assign glide_en_d[gr] = !(pins.glide_conn[gr] && pins.glide_n[gr]);
		end
	endgenerate

	// Held copy of the position stands in for the processed row output
	assign hold_pos_d = pins.hold ? hold_pos_o : pos_d;

	// Read mux; unmapped addresses and idle cycles return zero
	logic [ssc_pkg::DATA_W-1:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[ssc_pkg::ST_RUNNING] = running;
		status_word[ssc_pkg::ST_POS_LSB +: POS_W] = pos_q;
		status_word[ssc_pkg::ST_HOLD] = pins.hold;
		status_word[ssc_pkg::ST_RETURN] = pins.ret;
		status_word[ssc_pkg::ST_GLIDE +: ssc_pkg::ROWS] = glide_en_o;
	end

	always_comb begin
		rdata_d = ssc_pkg::RDATA_RST;
		if (reg_re_i) begin
			case (reg_addr_i)
				ssc_pkg::REG_STATUS: rdata_d = status_word;
				ssc_pkg::REG_SWITCH: rdata_d = ssc_pkg::DATA_W'(switch_q);
				default:             rdata_d = ssc_pkg::RDATA_RST;
			endcase
		end
	end

	// Edge history and sequencer state
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prev_q <= '0;
			run_q  <= ssc_pkg::SSC_STOPPED;
			pos_q  <= POS_FIRST;
		end else begin
			prev_q <= pins;
			run_q  <= run_d;
			pos_q  <= pos_d;
		end
	end

	// Selector bank written by software
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			switch_q <= ssc_pkg::SWITCH_RST[SW_W-1:0];
		end else if (switch_wr) begin
			switch_q <= reg_wdata_i[SW_W-1:0];
		end
	end

	// Output flops, so every pin comes straight from a register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			step_led_o  <= '0;
			trig_o      <= '0;
			gate_o      <= 1'b0;
			row_led_o   <= '0;
			glide_en_o  <= '1;
			hold_pos_o  <= POS_FIRST;
			running_o   <= 1'b0;
			reg_rdata_o <= ssc_pkg::RDATA_RST;
		end else begin
			step_led_o  <= step_led_d;
			trig_o      <= trig_d;
			gate_o      <= gate_d;
			row_led_o   <= row_led_d;
			glide_en_o  <= glide_en_d;
			hold_pos_o  <= hold_pos_d;
			running_o   <= (run_d == ssc_pkg::SSC_RUNNING);
			reg_rdata_o <= rdata_d;
		end
	end

endmodule : ssc_top

`default_nettype wire

/* ssc_sva.sv */
// Port checker for the step sequencer control
`default_nettype none
module ssc_sva #(
	parameter int NUM_STEPS = 8
) (
	input wire logic			mclk_i,
	input wire logic			rst_i,
	input wire ssc_pkg::ssc_pins_s		pins_i,
	input wire logic [3:0]			reg_addr_i,
	input wire logic			reg_re_i,
	input wire logic [31:0]			reg_rdata_o,
	input wire logic [NUM_STEPS-1:0]	step_led_o,
	input wire logic [2:0]			trig_o,
	input wire logic			gate_o,
	input wire logic [3:0]			row_led_o,
	input wire logic [1:0]			glide_en_o,
	input wire logic [$clog2(NUM_STEPS)-1:0]	hold_pos_o,
	input wire logic			running_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]		age_q;
	logic [NUM_STEPS-1:0]	prev_q;
	wire			ok = age_q > 4'h7;
	// Age gate keeps pin checks clear of the sync pipeline after reset
	always_ff @(posedge mclk_i) begin
		prev_q <= step_led_o;
		age_q <= rst_i ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	chk_one_lit: assert property (ok |-> $onehot(step_led_o))
		else $error("step lamps not one-hot");
	chk_step_move: assert property (ok && $past(running_o) && step_led_o != prev_q
		|-> step_led_o == {prev_q[NUM_STEPS-2:0], prev_q[NUM_STEPS-1]} || step_led_o == 1)
		else $error("step moved by other than one");
	chk_stop_frozen: assert property (!$past(running_o) && !running_o && step_led_o != prev_q
		|-> step_led_o == 1) else $error("stopped sequence advanced");
	chk_rd_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0)
		else $error("read data outside its cycle");
	chk_rd_status: assert property ($past(reg_re_i) && $past(reg_addr_i) == 4'h4
		|-> reg_rdata_o[0] == $past(running_o) && reg_rdata_o[13:12] == $past(glide_en_o))
		else $error("status word wrong");
	chk_stop_quiet: assert property (!$past(running_o) && !running_o |-> trig_o == '0)
		else $error("trigger while stopped");
	chk_row_match: assert property (ok |-> gate_o == row_led_o[3] && (trig_o & ~row_led_o[2:0]) == '0)
		else $error("row output off its assignment");
	chk_ret_level: assert property ((ok && pins_i.ret)[*5] |-> step_led_o == 1)
		else $error("return level not holding step one");
	chk_hold_frz: assert property ((ok && pins_i.hold)[*5] |-> hold_pos_o == $past(hold_pos_o))
		else $error("held output moved");
	chk_glide_map: assert property ((ok && $stable(pins_i.glide_n) && $stable(pins_i.glide_conn))[*5]
		|-> glide_en_o == ~(pins_i.glide_n & pins_i.glide_conn)) else $error("glide enable wrong");
endmodule : ssc_sva
bind ssc_top ssc_sva #(.NUM_STEPS(NUM_STEPS)) u_ssc_sva (.mclk_i, .rst_i, .pins_i, .reg_addr_i, .reg_re_i,
	.reg_rdata_o, .step_led_o, .trig_o, .gate_o, .row_led_o, .glide_en_o, .hold_pos_o, .running_o);
`default_nettype wire

/* ssc_src.sv */
// Control source that drives the sequencer's socket pins
`default_nettype none
module ssc_src (
	input wire logic		mclk_i,
	input wire logic		run_i,
	input wire logic		halt_i,
	input wire logic		ret_i,
	input wire logic		hold_i,
	input wire logic		fb_i,
	input wire logic		pulse_i,
	input wire logic [3:0]		glide_i,
	output var ssc_pkg::ssc_pins_s	pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]	cnt_q = 4'h0;
	// Clock pulse: six cycles high then at least seven low, so the far side sees it whole
	always @(posedge mclk_i) begin
		cnt_q <= (pulse_i && cnt_q == 4'h0) ? 4'hc : cnt_q - {3'h0, cnt_q != 4'h0};
	end
	// Trigger feedback joins the return line, as a patch cable would
	assign pins_o = '{run_i, halt_i, cnt_q > 4'h6, ret_i | fb_i, hold_i, glide_i[3:2], glide_i[1:0]};
endmodule : ssc_src
`default_nettype wire

/* step_sequencer_control_tb.sv */
// Self-checking bench for the step sequencer control
`default_nettype none
module step_sequencer_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic		mclk_i = 1'b0, rst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0, pend = 1'b0;
	logic		run = 1'b0, halt = 1'b0, ret = 1'b0, hold = 1'b0, fb = 1'b0, pulse = 1'b0, fh = 1'b0;
	logic [3:0]	reg_addr_i = 4'h0, glide = 4'h0, row_led_o;
	logic [31:0]	reg_wdata_i = 32'h0, reg_rdata_o, rs = 32'h31, swv = 32'h0;
	logic [7:0]	step_led_o;
	logic [2:0]	trig_o, hold_pos_o, pos, hp = 3'h0;
	logic [1:0]	glide_en_o, gx;
	logic		gate_o, running_o;
	ssc_pkg::ssc_pins_s	pins_i;
	logic [38:0]	q[$];
	int		mismatches = 0, cmp_count = 0, cyc = 0;
	ssc_top u_ssc_top (.mclk_i, .rst_i, .pins_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
		.step_led_o, .trig_o, .gate_o, .row_led_o, .glide_en_o, .hold_pos_o, .running_o);
	// Row 1 trigger may be patched into halt for the one-shot run
	ssc_src u_ssc_src (.mclk_i, .run_i(run), .halt_i(halt | (fh & trig_o[0])), .ret_i(ret), .hold_i(hold),
		.fb_i(fb & trig_o[1]), .pulse_i(pulse), .glide_i(glide), .pins_o(pins_i));
	always #5 mclk_i = ~mclk_i;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	// Expected status word: glide, pins, position, run state
	function automatic logic [31:0] st(input logic r, input logic [2:0] p, input logic [1:0] h);
		return {18'h0, gx, 2'h0, h, 1'h0, p, 3'h0, r};
	endfunction : st
	// Expected row lamps {gate, t3, t2, t1} of a step from the selector word
	function automatic logic [3:0] rows(input logic [31:0] sw, input logic [2:0] p);
		logic [3:0] n;
		n = sw[p*4 +: 4];
		return {n[3:2] == 2'h2, n[3:2] == 2'h1, n[1:0] == 2'h2, n[1:0] == 2'h1};
	endfunction : rows
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_of_test();
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic w(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : w
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		if (a == 4'h8)
			swv = d;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		w(1);
		reg_we_i <= 1'b0;
		w(1);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		if (a == 4'h4 && !e[8])
			hp = e[6:4];
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		q.push_back({hp, a, e});
		w(1);
		reg_re_i <= 1'b0;
		w(1);
	endtask : rd
	task automatic stp(input int n);
		repeat (n) begin
			pulse <= 1'b1;
			w(1);
			pulse <= 1'b0;
			w(13);
		end
	endtask : stp
	// Ceiling well above the planned run length
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			mismatches++;
			end_of_test();
		end
	end
	// Read data stand one cycle after the strobe; checked mid-cycle with the lamps
	always @(negedge mclk_i) begin
		if (pend) begin
			automatic logic [38:0] n = q.pop_front();
			chk("read data", reg_rdata_o, n[31:0]);
			if (n[35:32] == 4'h4) begin
				chk("running", 32'(running_o), 32'(n[0]));
				chk("step lamps", 32'(step_led_o), 32'(8'h1 << n[6:4]));
				chk("held output", 32'(hold_pos_o), 32'(n[38:36]));
				chk("row lamps", 32'(row_led_o), 32'(rows(swv, n[6:4])));
				chk("gate", 32'(gate_o), 32'(rows(swv, n[6:4]) >> 3));
			end
		end
		pend = reg_re_i;
	end
	initial begin
		rs = xs(rs);
		glide <= rs[3:0];
		gx = ~(rs[3:2] & rs[1:0]);
		w(12);
		rst_i <= 1'b0;
		w(6);
		rd(4'hc, 32'h0);
		rd(4'h0, 32'h0);
		wr(4'h4, 32'h1);
		rd(4'h4, st(0, 0, 0));
		wr(4'h0, 32'h1);
		for (int i = 1; i < 10; i++) begin
			wr(4'h0, 32'h4);
			rd(4'h4, st(1, 3'(i), 0));
		end
		wr(4'h0, 32'h8);
		rd(4'h4, st(1, 0, 0));
		wr(4'h0, 32'h3);
		wr(4'h0, 32'h4);
		rd(4'h4, st(0, 0, 0));
		run <= 1'b1;
		w(6);
		stp(2);
		rd(4'h4, st(1, 2, 0));
		halt <= 1'b1;
		w(2);
		halt <= 1'b0;
		stp(1);
		rd(4'h4, st(0, 2, 0));
		run <= 1'b0;
		w(2);
		run <= 1'b1;
		ret <= 1'b1;
		w(6);
		stp(1);
		rd(4'h4, st(1, 0, 2'h2));
		ret <= 1'b0;
		hold <= 1'b1;
		w(6);
		stp(1);
		rd(4'h4, st(1, 1, 2'h1));
		hold <= 1'b0;
		pos = 3'h1;
		rs = xs(rs);
		wr(4'h8, rs);
		rd(4'h8, rs);
		repeat (3) begin
			rs = xs(rs);
			stp(int'(rs[2:0]) + 1);
			pos += rs[2:0] + 3'h1;
			rd(4'h4, st(1, pos, 0));
		end
		wr(4'h8, 32'h2000);
		wr(4'h0, 32'h8);
		fb <= 1'b1;
		stp(3);
		rd(4'h4, st(1, 0, 0));
		fb <= 1'b0;
		wr(4'h8, 32'h100);
		fh <= 1'b1;
		stp(4);
		rd(4'h4, st(0, 2, 0));
		fh <= 1'b0;
		wr(4'h0, 32'h4);
		wr(4'h0, 32'h2);
		wr(4'h0, 32'h8);
		rd(4'h4, st(0, 0, 0));
		end_of_test();
	end
endmodule : step_sequencer_control_tb
`default_nettype wire
